// >>> core/csr_defs.vh
// Constants for the CPU system-register block.
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
// Register word offsets (byte address is four times the index).
`define CSR_IDX_FLAGS 4'h0
`define CSR_IDX_SP 4'h2
`define CSR_IDX_SYSCTL 4'h8
`define CSR_IDX_CORE_CTL 4'hC
`define CSR_IDX_CORE_STAT 4'hD
`define CSR_IDX_MEM_ADDR 4'hE
`define CSR_IDX_MEM_DATA 4'hF
// Flag register fields.
`define CSR_FLAG_RSVD 4'hF
`define CSR_FLAG_OV 3
`define CSR_FLAG_HC 2
`define CSR_FLAG_CY 1
`define CSR_FLAG_Z 0
// System control register fields.
`define CSR_SC_BIAS 4
`define CSR_SC_LVR_DIS 2
`define CSR_SC_WDT_HI 1
`define CSR_SC_MASK 8'h17
// Core control register fields.
`define CSR_CC_PROT 0
`define CSR_CC_EDGE_LO 1
`define CSR_CC_EDGE_HI 2
`define CSR_CC_GATE 3
`define CSR_CC_PWM2X 4
`define CSR_CC_TMR2X 5
`define CSR_CC_INDIR 6
// Comparator interrupt edge selections.
`define CSR_EDGE_BOTH 2'h0
`define CSR_EDGE_RISE 2'h1
`define CSR_EDGE_FALL 2'h2
// Program memory map.
`define CSR_RESET_VEC 11'h000
`define CSR_IRQ_VEC 11'h010
`define CSR_SYS_BASE 11'h7E0
`define CSR_PROT_LIMIT 11'h100
// Data memory map.
`define CSR_BIT_TOP 7'h3F
// Watchdog periods in slow oscillator clocks.
`define CSR_WDT_8K 19'h02000
`define CSR_WDT_16K 19'h04000
`define CSR_WDT_64K 19'h10000
`define CSR_WDT_256K 19'h40000
// Timer clock field value that selects the fast oscillator.
`define CSR_TMR_FAST_SRC 4'h2
`endif

// >>> core/csr_data_ram.v
// Data memory of 128 bytes with registered read data.
`timescale 1ns/10ps
module csr_data_ram
#(
  parameter AW = 7,
  parameter DW = 8
)
(
  // Clock.
  input wire clk_i,
  // Write port.
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  // Read port.
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  // Writes land on the edge; reads come out one cycle later.
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end

endmodule

// >>> core/csr_system_regs.v
// CPU system registers, flags, stack pointer and build options.
`timescale 1ns/10ps
`include "csr_defs.vh"
module csr_system_regs
#(
  parameter PC_W = 11,
  parameter DA_W = 7
)
(
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Core ALU flag update.
  input wire alu_upd_i,
  input wire [3:0] alu_flags_i,
  input wire [3:0] alu_mask_i,
  // Core stack pointer update.
  input wire sp_upd_i,
  input wire [7:0] sp_new_i,
  // Core sequencing.
  input wire irq_take_i,
  input wire pc_step_i,
  input wire [PC_W-1:0] pc_next_i,
  output reg [PC_W-1:0] fetch_addr_o,
  // Program read-back request.
  input wire [PC_W-1:0] rb_addr_i,
  output reg rb_allow_o,
  // Comparator and timer/PWM sources.
  input wire cmp_i,
  input wire [3:0] tmr_src_i,
  input wire pwm_fast_sel_i,
  input wire [2:0] pwm_i,
  // Control outputs.
  output reg bias_en_o,
  output reg lvr_en_o,
  output reg [18:0] wdt_period_o,
  output reg cmp_irq_o,
  output reg [2:0] pwm_o,
  output reg pwm_clk2x_o,
  output reg tmr_clk2x_o,
  output reg indir_busy_o
);

  // Two-cycle indirect access states.
  // Idle serves every direct access; the pointer state lasts one clock.
  localparam ST_IDLE = 1'b0;
  localparam ST_PTR = 1'b1;

  // Architectural registers. Only the low nibble of the flag register is
  // stored; the reserved top nibble is produced by the read mux.
  reg [7:0] flags_reg;
  reg [7:0] sp_reg;
  reg [7:0] sysctl_reg;
  reg [6:0] opt_reg;
  reg [DA_W-1:0] mem_addr_reg;
  reg st_reg;
  reg st_next;
  reg [DA_W-1:0] ptr_reg;
  reg [2:0] cmp_sync_reg;
  reg cmp_prev_reg;
  reg ram_we;
  reg [DA_W-1:0] ram_raddr;
  reg [DA_W-1:0] ram_waddr;
  reg [7:0] ram_wdata;
  reg [31:0] rd_next;
  wire [7:0] ram_rdata;
  wire [3:0] idx;
  wire acc;
  wire wr;
  wire cmp_rise;
  wire cmp_fall;
  wire edge_hit;
  reg bit_ok_reg;

  // Watchdog period decode, used for output and readback.
  // The period counts slow oscillator clocks; the watchdog lives elsewhere.
  function [18:0] csr_wdt;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: csr_wdt = `CSR_WDT_8K;
        2'h1: csr_wdt = `CSR_WDT_16K;
        2'h2: csr_wdt = `CSR_WDT_64K;
        default: csr_wdt = `CSR_WDT_256K;
      endcase
    end
  endfunction

  // Only the low bit area is reachable by bit instructions.
  function csr_bit_ok;
    input [DA_W-1:0] a;
    begin
      csr_bit_ok = (a <= `CSR_BIT_TOP);
    end
  endfunction

  // Register space decode is separate from both memories.
  // A request is taken while cyc and stb stand and no ack is out, so a
  // held request is never served twice. Only byte lane 0 carries write data.
  assign idx = wb_adr_i[5:2];
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i & wb_sel_i[0];

  // Data memory: one store serves data, pointers and stack.
  // The stack pointer only names a byte here; pushes are the core's work.
  csr_data_ram #(.AW(DA_W), .DW(8)) u_ram
  (
    .clk_i(clk_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_raddr),
    .rdata_o(ram_rdata)
  );

  // Memory port steering: direct, or through a pointer byte.
  // The pointer byte is already on the read port when an indirect
  // request arrives, because the read address rests on the address
  // register while the bus is idle. Sending that byte straight back
  // as the next read address saves a cycle, so the target byte stands
  // on the read port in the second cycle, when the answer is formed.
  always @*
  begin
    ram_we = 1'b0;
    ram_waddr = mem_addr_reg;
    ram_wdata = wb_dat_i[7:0];
    ram_raddr = mem_addr_reg;
    st_next = st_reg;
    if (st_reg == ST_PTR)
    begin
      // Second cycle: read or write the byte that the pointer names.
      ram_raddr = ptr_reg;
      ram_waddr = ptr_reg;
      ram_we = wr;
      st_next = ST_IDLE;
    end
    else if (acc && idx == `CSR_IDX_MEM_DATA)
    begin
      if (opt_reg[`CSR_CC_INDIR])
      begin
        // First cycle: the byte at the address register is the pointer.
        ram_raddr = ram_rdata[DA_W-1:0];
        st_next = ST_PTR;
      end
      else if (wr)
      begin
        ram_we = 1'b1;
      end
    end
  end

  // Read mux for the register file.
  // Reserved flag bits read as ones, the write-only control bits read as
  // zero, and unmapped indices read as zero. The core status word carries
  // the watchdog period and, in its top bit, the bit window verdict.
  always @*
  begin
    rd_next = 32'h0000_0000;
    case (idx)
      `CSR_IDX_FLAGS: rd_next[7:0] = {`CSR_FLAG_RSVD, flags_reg[3:0]};
      `CSR_IDX_SP: rd_next[7:0] = sp_reg;
      `CSR_IDX_SYSCTL: rd_next[7:0] = 8'h00;
      `CSR_IDX_CORE_CTL: rd_next[6:0] = opt_reg;
      `CSR_IDX_CORE_STAT: rd_next = {bit_ok_reg, 12'h000, csr_wdt(sysctl_reg[1:0])};
      `CSR_IDX_MEM_ADDR: rd_next[7:0] = {1'b0, mem_addr_reg};
      `CSR_IDX_MEM_DATA: rd_next[7:0] = ram_rdata;
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // Comparator edge detection on the agreed synchroniser stages.
  // The filtered level only moves once the second and third stages agree,
  // so a pin that bounces for one clock raises no edge. The first stage
  // feeds only the second, which keeps a metastable value out of the decode.
  assign cmp_rise = cmp_sync_reg[1] & cmp_sync_reg[2] & ~cmp_prev_reg;
  assign cmp_fall = ~cmp_sync_reg[1] & ~cmp_sync_reg[2] & cmp_prev_reg;
  assign edge_hit = (opt_reg[`CSR_CC_EDGE_HI:`CSR_CC_EDGE_LO] == `CSR_EDGE_RISE) ? cmp_rise :
                    (opt_reg[`CSR_CC_EDGE_HI:`CSR_CC_EDGE_LO] == `CSR_EDGE_FALL) ? cmp_fall :
                    (cmp_rise | cmp_fall);

  // Bus handshake, indirect sequencing and register writes.
  // Ack rises one clock after a request is taken and stands for one cycle;
  // an indirect data access adds the pointer cycle. A write lands on the
  // edge that raises ack, and read data is loaded on that same edge.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      flags_reg <= 8'h00;
      sp_reg <= 8'h00;
      sysctl_reg <= 8'h00;
      opt_reg <= 7'h00;
      mem_addr_reg <= {DA_W{1'b0}};
      st_reg <= ST_IDLE;
      ptr_reg <= {DA_W{1'b0}};
    end
    else
    begin
      st_reg <= st_next;
      // Keep the pointer byte for the second cycle of an indirect access.
      if (st_reg == ST_IDLE && st_next == ST_PTR)
      begin
        ptr_reg <= ram_rdata[DA_W-1:0];
      end
      // Ack in the cycle after the request, or after the pointer cycle.
      wb_ack_o <= acc && (st_next == ST_IDLE);
      if (acc && st_next == ST_IDLE)
      begin
        wb_dat_o <= rd_next;
      end
      // Flag updates from the core, then software writes win.
      // A software write in the same cycle as a core update therefore wins.
      if (alu_upd_i)
      begin
        flags_reg[3:0] <= (flags_reg[3:0] & ~alu_mask_i) | (alu_flags_i & alu_mask_i);
      end
      if (sp_upd_i)
      begin
        sp_reg <= sp_new_i;
      end
      if (wr && st_next == ST_IDLE)
      begin
        case (idx)
          `CSR_IDX_FLAGS: flags_reg[3:0] <= wb_dat_i[3:0];
          `CSR_IDX_SP: sp_reg <= wb_dat_i[7:0];
          `CSR_IDX_SYSCTL: sysctl_reg <= wb_dat_i[7:0] & `CSR_SC_MASK;
          `CSR_IDX_CORE_CTL: opt_reg <= wb_dat_i[6:0];
          `CSR_IDX_MEM_ADDR: mem_addr_reg <= wb_dat_i[DA_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Program counter: reset vector, interrupt vector, or next word.
  // The interrupt vector wins over a step in the same cycle, since the
  // core must not fetch past an accepted interrupt.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fetch_addr_o <= `CSR_RESET_VEC;
    end
    else if (irq_take_i)
    begin
      fetch_addr_o <= `CSR_IRQ_VEC;
    end
    else if (pc_step_i)
    begin
      fetch_addr_o <= pc_next_i;
    end
  end

  // Comparator synchroniser and derived outputs.
  // Every control output is registered here so that the far blocks see
  // clean levels; each follows its source one clock later.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmp_sync_reg <= 3'h0;
      cmp_prev_reg <= 1'b0;
      cmp_irq_o <= 1'b0;
      pwm_o <= 3'h0;
      rb_allow_o <= 1'b0;
      bias_en_o <= 1'b0;
      lvr_en_o <= 1'b1;
      wdt_period_o <= `CSR_WDT_8K;
      pwm_clk2x_o <= 1'b0;
      tmr_clk2x_o <= 1'b0;
      indir_busy_o <= 1'b0;
    end
    else
    begin
      cmp_sync_reg <= {cmp_sync_reg[1:0], cmp_i};
      if (cmp_sync_reg[1] == cmp_sync_reg[2])
      begin
        cmp_prev_reg <= cmp_sync_reg[2];
      end
      cmp_irq_o <= edge_hit;
      pwm_o <= opt_reg[`CSR_CC_GATE] ? (pwm_i & {3{cmp_prev_reg}}) : pwm_i;
      // Protection hides every word from the limit upward, 7/8 of the store;
      // without it the whole store, system words included, reads back.
      rb_allow_o <= !opt_reg[`CSR_CC_PROT] || (rb_addr_i < `CSR_PROT_LIMIT);
      bias_en_o <= sysctl_reg[`CSR_SC_BIAS];
      lvr_en_o <= ~sysctl_reg[`CSR_SC_LVR_DIS];
      wdt_period_o <= csr_wdt(sysctl_reg[`CSR_SC_WDT_HI:0]);
      pwm_clk2x_o <= pwm_fast_sel_i & opt_reg[`CSR_CC_PWM2X];
      tmr_clk2x_o <= (tmr_src_i == `CSR_TMR_FAST_SRC) & opt_reg[`CSR_CC_TMR2X];
      indir_busy_o <= (st_next == ST_PTR);
    end
  end

  // Bit instructions are honoured only in the low window. The verdict for
  // the address register is published in the core status word, so that a
  // bit operation outside the window can be caught before it is issued.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bit_ok_reg <= 1'b0;
    end
    else
    begin
      bit_ok_reg <= csr_bit_ok(mem_addr_reg);
    end
  end

endmodule

// >>> bench/csr_system_regs_checker.sv
// Assertion checker for the CPU system registers.
`timescale 1ns/10ps
module csr_system_regs_checker
#(
  parameter PC_W = 11
)
(
  // Clock, reset and bus.
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Core side and control outputs.
  input wire irq_take_i,
  input wire [PC_W-1:0] fetch_addr_o,
  input wire [PC_W-1:0] rb_addr_i,
  input wire rb_allow_o,
  input wire lvr_en_o,
  input wire bias_en_o,
  input wire [18:0] wdt_period_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // All properties share the bus clock; all but the two reset checks are disabled by its reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_one;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[5:2] != 4'hF |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack late");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  property p_flag_ones;
    wb_ack_o && !wb_we_i && wb_adr_i == 6'h00 |-> wb_dat_o[7:4] == 4'hF;
  endproperty
  a_flag_ones: assert property (p_flag_ones) else $error("flag top bits");
  property p_ctl_rd0;
    wb_ack_o && !wb_we_i && wb_adr_i == 6'h20 |-> wb_dat_o[7:0] == 8'h00;
  endproperty
  a_ctl_rd0: assert property (p_ctl_rd0) else $error("control read");
  property p_rst_vec;
    disable iff (1'b0) rst_i |=> fetch_addr_o == 'h000;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset fetch");
  property p_rst_ctl;
    disable iff (1'b0) rst_i |=> lvr_en_o && !bias_en_o && wdt_period_o == 19'h02000;
  endproperty
  a_rst_ctl: assert property (p_rst_ctl) else $error("reset ctl");
  property p_irq_vec;
    irq_take_i |=> fetch_addr_o == 'h010;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("irq fetch");
  property p_wdt_set;
    wdt_period_o inside {19'h02000, 19'h04000, 19'h10000, 19'h40000};
  endproperty
  a_wdt_set: assert property (p_wdt_set) else $error("wdt period");
  property p_rb_low;
    rb_addr_i < 'h100 |=> rb_allow_o;
  endproperty
  a_rb_low: assert property (p_rb_low) else $error("readback low");
endmodule
bind csr_system_regs csr_system_regs_checker #(.PC_W(PC_W)) i_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_take_i, .fetch_addr_o,
  .rb_addr_i, .rb_allow_o, .lvr_en_o, .bias_en_o, .wdt_period_o);

// >>> bench/cpu_system_registers_tb_top.sv
// Testbench for the CPU system registers.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module cpu_system_registers_tb_top;
  // ----------------------------------------
  // Stimulus signals
  // ----------------------------------------
  reg clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [5:0] wb_adr_i = 0;
  reg [3:0] wb_sel_i = 4'h1, alu_flags_i = 0, alu_mask_i = 0, tmr_src_i = 4'h2;
  reg [31:0] wb_dat_i = 0;
  reg alu_upd_i = 0, sp_upd_i = 0, irq_take_i = 0, pc_step_i = 0, cmp_i = 0;
  reg pwm_fast_sel_i = 1;
  reg [7:0] sp_new_i = 0;
  reg [31:0] rd;
  reg busy;
  reg [10:0] pc_next_i = 0, rb_addr_i = 0;
  reg [2:0] pwm_i = 0;
  wire [31:0] wb_dat_o;
  wire [10:0] fetch_addr_o;
  wire [18:0] wdt_period_o;
  wire [2:0] pwm_o;
  wire wb_ack_o, rb_allow_o, bias_en_o, lvr_en_o, cmp_irq_o, pwm_clk2x_o, tmr_clk2x_o;
  wire indir_busy_o;
  reg [18:0] wdt_tab [0:3] = '{19'h02000, 19'h04000, 19'h10000, 19'h40000};
  integer fail_count = 0, n_tests = 0, k, wt, hits;
  csr_system_regs i_csr_system_regs (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .alu_upd_i, .alu_flags_i,
    .alu_mask_i, .sp_upd_i, .sp_new_i, .irq_take_i, .pc_step_i, .pc_next_i, .fetch_addr_o,
    .rb_addr_i, .rb_allow_o, .cmp_i, .tmr_src_i, .pwm_fast_sel_i, .pwm_i, .bias_en_o,
    .lvr_en_o, .wdt_period_o, .cmp_irq_o, .pwm_o, .pwm_clk2x_o, .tmr_clk2x_o, .indir_busy_o);
  // Clock of 20 ns period.
  always #10 clk_i = ~clk_i;
  // One Wishbone cycle; read data lands in rd.
  task wb(input reg w, input reg [5:0] a, input reg [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wt = 0;
    busy = 1'b0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk_i);
      wt = wt + 1;
      if (indir_busy_o === 1'b1)
      begin
        busy = 1'b1;
      end
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Flags: software access and ALU update of selected bits.
  task t_flags;
    wb(1, 6'h00, 8'h0A);
    wb(0, 6'h00, 8'h00);
    `CHK("flags", 8'hFA, rd)
    @(posedge clk_i);
    alu_upd_i <= 1'b1;
    alu_flags_i <= 4'h5;
    alu_mask_i <= 4'hD;
    @(posedge clk_i);
    alu_upd_i <= 1'b0;
    wb(0, 6'h00, 8'h00);
    `CHK("alu flags", 8'hF7, rd)
    $display("test flags done");
  endtask
  // System control: every watchdog code, bias and low-voltage reset.
  task t_sysctl;
    for (k = 0; k < 4; k++)
    begin
      wb(1, 6'h20, {3'b111, k[0], 1'b1, k[1], k[1:0]});
      wb(0, 6'h20, 8'h00);
      `CHK("sysctl read", 8'h00, rd)
      `CHK("wdt", wdt_tab[k], wdt_period_o)
      `CHK("bias", k[0], bias_en_o)
      `CHK("lvr", !k[1], lvr_en_o)
      wb(0, 6'h34, 8'h00);
      `CHK("wdt read", wdt_tab[k], rd[18:0])
    end
    $display("test sysctl done");
  endtask
  // Stack pointer from software and from the core.
  task t_sp;
    wb(1, 6'h08, 8'h7E);
    wb(0, 6'h08, 8'h00);
    `CHK("sp", 8'h7E, rd)
    @(posedge clk_i);
    sp_upd_i <= 1'b1;
    sp_new_i <= 8'h40;
    @(posedge clk_i);
    sp_upd_i <= 1'b0;
    wb(0, 6'h08, 8'h00);
    `CHK("sp core", 8'h40, rd)
    $display("test sp done");
  endtask
  // Read-back guard of the program store with one request.
  task rb(input reg [10:0] a, input reg e);
    @(posedge clk_i);
    rb_addr_i <= a;
    repeat (2) @(posedge clk_i);
    `CHK("readback", e, rb_allow_o)
  endtask
  // Interrupt vector, unmapped space, protection and clock options.
  task t_core;
    @(posedge clk_i);
    irq_take_i <= 1'b1;
    @(posedge clk_i);
    irq_take_i <= 1'b0;
    @(posedge clk_i);
    `CHK("irq vec", 11'h010, fetch_addr_o)
    wb(0, 6'h04, 8'h00);
    `CHK("unmapped", 8'h00, rd)
    wb(1, 6'h30, 8'h31);
    wb(0, 6'h30, 8'h00);
    `CHK("core ctl", 8'h31, rd)
    `CHK("pwm2x", 1'b1, pwm_clk2x_o)
    `CHK("tmr2x", 1'b1, tmr_clk2x_o)
    pwm_fast_sel_i <= 1'b0;
    tmr_src_i <= 4'h3;
    repeat (2) @(posedge clk_i);
    `CHK("pwm sel off", 1'b0, pwm_clk2x_o)
    `CHK("tmr src other", 1'b0, tmr_clk2x_o)
    pwm_fast_sel_i <= 1'b1;
    tmr_src_i <= 4'h2;
    rb(11'h0FF, 1'b1);
    rb(11'h100, 1'b0);
    rb(11'h7FF, 1'b0);
    wb(1, 6'h30, 8'h00);
    rb(11'h7FF, 1'b1);
    `CHK("pwm1x", 1'b0, pwm_clk2x_o)
    `CHK("tmr1x", 1'b0, tmr_clk2x_o)
    $display("test core done");
  endtask
  // Data memory: direct, indirect read and write, and the bit window.
  task t_mem;
    wb(1, 6'h38, 8'h10);
    wb(1, 6'h3C, 8'h55);
    wb(1, 6'h38, 8'h7F);
    wb(1, 6'h3C, 8'h10);
    wb(0, 6'h3C, 8'h00);
    `CHK("mem top", 8'h10, rd)
    `CHK("direct wait", 1, wt)
    wb(1, 6'h30, 8'h40);
    wb(0, 6'h3C, 8'h00);
    `CHK("indirect read", 8'h55, rd)
    `CHK("indirect wait", 2, wt)
    `CHK("indirect busy", 1'b1, busy)
    wb(1, 6'h3C, 8'hAA);
    wb(1, 6'h30, 8'h00);
    wb(1, 6'h38, 8'h10);
    wb(0, 6'h3C, 8'h00);
    `CHK("indirect write", 8'hAA, rd)
    wb(1, 6'h38, 8'h3F);
    wb(0, 6'h34, 8'h00);
    `CHK("bit window top", 1'b1, rd[31])
    wb(1, 6'h38, 8'h40);
    wb(0, 6'h34, 8'h00);
    `CHK("bit window out", 1'b0, rd[31])
    $display("test mem done");
  endtask
  // One comparator level change; counts interrupt pulses that follow.
  task cmp_edge(input reg v, input integer e);
    @(posedge clk_i);
    cmp_i <= v;
    hits = 0;
    repeat (8)
    begin
      @(posedge clk_i);
      if (cmp_irq_o === 1'b1)
      begin
        hits = hits + 1;
      end
    end
    `CHK("cmp irq", e, hits)
  endtask
  // Comparator edge options and gating of the PWM outputs.
  task t_cmp;
    wb(1, 6'h30, 8'h00);
    cmp_edge(1'b1, 1);
    cmp_edge(1'b0, 1);
    wb(1, 6'h30, 8'h02);
    cmp_edge(1'b1, 1);
    cmp_edge(1'b0, 0);
    wb(1, 6'h30, 8'h04);
    cmp_edge(1'b1, 0);
    cmp_edge(1'b0, 1);
    pwm_i <= 3'h5;
    wb(1, 6'h30, 8'h08);
    repeat (2) @(posedge clk_i);
    `CHK("pwm gated low", 3'h0, pwm_o)
    cmp_edge(1'b1, 1);
    `CHK("pwm gated high", 3'h5, pwm_o)
    wb(1, 6'h30, 8'h00);
    cmp_edge(1'b0, 1);
    `CHK("pwm ungated", 3'h5, pwm_o)
    $display("test cmp done");
  endtask
  // Program counter stepping, then a second reset in mid-run.
  task t_reset;
    @(posedge clk_i);
    pc_step_i <= 1'b1;
    pc_next_i <= 11'h123;
    @(posedge clk_i);
    pc_step_i <= 1'b0;
    @(posedge clk_i);
    `CHK("pc step", 11'h123, fetch_addr_o)
    wb(1, 6'h20, 8'h17);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("again fetch", 11'h000, fetch_addr_o)
    `CHK("again wdt", 19'h02000, wdt_period_o)
    `CHK("again bias", 1'b0, bias_en_o)
    `CHK("again lvr", 1'b1, lvr_en_o)
    $display("test reset done");
  endtask
  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence after six reset cycles.
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("reset fetch", 11'h000, fetch_addr_o)
    `CHK("reset wdt", 19'h02000, wdt_period_o)
    `CHK("reset lvr", 1'b1, lvr_en_o)
    t_flags;
    t_sysctl;
    t_sp;
    t_core;
    t_mem;
    t_cmp;
    t_reset;
    end_of_test;
  end
  // Watchdog against a hung handshake.
  initial
  begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    end_of_test;
  end
endmodule
